// ### core/lane_regs_pkg.sv
package lane_regs_pkg;
   // ---------------------------------------------------------------
   // register indices, byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [13:0] IDX_TRAIN_CTL = 14'h0096;
   localparam logic [13:0] IDX_TRAIN_STATUS = 14'h0097;
   localparam logic [13:0] IDX_ABILITY = 14'h05dc;
   localparam logic [13:0] IDX_PRBS_CTL = 14'h05dd;
   localparam logic [13:0] IDX_ERR_CNT0 = 14'h06a4;
   localparam logic [13:0] IDX_IRQ_STATUS = 14'h0800;
   localparam logic [13:0] IDX_IRQ_MASK = 14'h0801;
   localparam int NUM_LANES = 4;
   localparam int ADDR_W = 16;

   // ---------------------------------------------------------------
   // field positions and constant values
   // ---------------------------------------------------------------
   localparam logic [15:0] ABILITY_VALUE = 16'h1029;
   localparam logic [15:0] PRBS_CTL_RESET = 16'h0000;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam int BIT_PRBS31_SEL = 7;
   localparam int BIT_PRBS9_SEL = 6;
   localparam int BIT_TX_GEN_EN = 3;
   localparam int BIT_RX_CHK_EN = 0;
   localparam int BIT_TRAIN_EN = 1;
   localparam int BIT_TRAIN_RESTART = 0;
   localparam logic [15:0] ERR_CNT_MAX = 16'hffff;
   localparam int TRAIN_WAIT_CYCLES = 8192;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic fail;
      logic startup;
      logic lock;
      logic ready;
   } lane_status_t;

   typedef struct packed {
      logic gen_en;
      logic chk_en;
      logic sel_prbs31;
      logic sel_prbs9;
   } prbs_drive_t;

   typedef struct packed {
      logic [ADDR_W-1:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_RUN = 2'b01,
      ST_DONE = 2'b10,
      ST_FAIL = 2'b11
   } train_state_t;
endpackage : lane_regs_pkg

// ### core/lane_trainer.sv
`timescale 1ns/100ps
module lane_trainer #(
   parameter int WAIT_CYCLES = lane_regs_pkg::TRAIN_WAIT_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic train_en,
   input wire logic restart,
   input wire logic frame_seen,
   input wire logic lane_ready,
   input wire logic lane_fail,
   output lane_regs_pkg::lane_status_t status
);
   import lane_regs_pkg::*;

   train_state_t state;
   logic [$clog2(WAIT_CYCLES+1)-1:0] wait_cnt;

   // ---------------------------------------------------------------
   // start-up protocol
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= ST_OFF;
         wait_cnt <= '0;
      end else if (!train_en) begin // [RULE16]
         state <= ST_OFF;
         wait_cnt <= '0;
      end else if (restart) begin // [RULE17]
         state <= ST_RUN;
         wait_cnt <= '0;
      end else begin
         case (state)
            ST_OFF: begin
               state <= ST_RUN;
               wait_cnt <= '0;
            end
            ST_RUN: begin
               wait_cnt <= wait_cnt + 1'b1;
               if (lane_fail || wait_cnt == WAIT_CYCLES[$bits(wait_cnt)-1:0])
                  state <= ST_FAIL;
               else if (lane_ready && frame_seen)
                  state <= ST_DONE;
            end
            default: state <= state;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // status flags, untouched by software reset
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin // [RULE18]
         status <= '0;
      end else begin
         status.fail <= (state == ST_FAIL); // [RULE1]
         status.startup <= (state == ST_RUN); // [RULE2]
         status.lock <= train_en && frame_seen; // [RULE3]
         status.ready <= (state == ST_DONE); // [RULE4]
      end
   end
endmodule : lane_trainer

// ### core/error_counter.sv
`timescale 1ns/100ps
module error_counter #(
   parameter int WIDTH = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic soft_reset,
   input wire logic enable,
   input wire logic bit_err,
   input wire logic clear,
   output logic [WIDTH-1:0] count
);
   import lane_regs_pkg::*;

   // ---------------------------------------------------------------
   // saturating count, cleared by a read
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst || soft_reset) begin
         count <= '0;
      end else if (clear) begin // [RULE15]
         count <= {{(WIDTH-1){1'b0}}, enable && bit_err};
      end else if (enable && bit_err && count != {WIDTH{1'b1}}) begin
         count <= count + 1'b1; // [RULE15]
      end
   end
endmodule : error_counter

// ### core/lane_regs.sv
`timescale 1ns/100ps
// How it works
// RULE1: status bits 15,11,7,3 flag a training failure per lane.
// RULE2: status bits 14,10,6,2 read one while start-up is in progress.
// RULE3: status bits 13,9,5,1 show training frame lock per lane.
// RULE4: status bits 12,8,4,0 show the receiver trained and ready.
// RULE5: ability bit 12 reads one: square-wave test supported.
// RULE6: ability bit 5 reads one, bit 4 reads zero.
// RULE7: ability bit 3 reads one: transmit PRBS31 generator exists.
// RULE8: ability bits 2 and 1 read zero.
// RULE9: ability bit 0 reads one: receive PRBS31 checker exists.
// RULE10: control bit 7 selects PRBS31, resets to zero.
// RULE11: control bit 6 selects PRBS9, resets to zero.
// RULE12: control bit 3 enables the transmit pattern generator.
// RULE13: control bits 2 and 1 are read-only zero.
// RULE14: control bit 0 enables the receive pattern checker.
// RULE15: per-lane 16-bit error counters saturate and clear on read.
// RULE16: training runs only while the training enable bit is set.
// RULE17: self-clearing restart bit restarts the start-up protocol.
// RULE18: training status clears on hard reset, kept on soft reset.
// RULE19: PRBS31 wins over PRBS9; reserved bits read zero.
module lane_regs #(
   parameter int LANES = lane_regs_pkg::NUM_LANES,
   parameter int WAIT_CYCLES = lane_regs_pkg::TRAIN_WAIT_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic soft_reset,
   input wire logic [lane_regs_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [LANES-1:0] frame_seen,
   input wire logic [LANES-1:0] lane_ready,
   input wire logic [LANES-1:0] lane_fail,
   input wire logic [LANES-1:0] bit_err,
   output lane_regs_pkg::prbs_drive_t prbs_drive,
   output logic irq
);
   import lane_regs_pkg::*;

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   apb_req_t req;
   lane_status_t [LANES-1:0] lane_status;
   lane_status_t [LANES-1:0] lane_status_q;
   logic [LANES-1:0][15:0] err_count;
   logic [LANES-1:0] err_clear;
   logic [15:0] prbs_ctl;
   logic train_en;
   logic train_restart;
   logic [2*LANES-1:0] irq_status;
   logic [2*LANES-1:0] irq_mask;
   logic [2*LANES-1:0] irq_event;
   logic [31:0] next_rdata;
   logic next_err;
   logic setup;
   logic write_done;
   logic [13:0] idx;
   logic [15:0] status_word;

   assign req = '{paddr: paddr, psel: psel, penable: penable,
                  pwrite: pwrite, pwdata: pwdata};

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   function automatic logic [13:0] word_index(input logic [ADDR_W-1:0] a);
      word_index = a[15:2];
   endfunction : word_index

   function automatic logic aligned(input logic [ADDR_W-1:0] a);
      aligned = (a[1:0] == 2'b00);
   endfunction : aligned

   function automatic logic is_counter(input logic [13:0] i, input int n);
      is_counter = (i == IDX_ERR_CNT0 + 14'(n));
   endfunction : is_counter

   assign idx = word_index(req.paddr);
   assign setup = req.psel && !req.penable;
   assign write_done = req.psel && req.penable && pready && req.pwrite;
   assign status_word = lane_status;

   // ---------------------------------------------------------------
   // per-lane training and error counting
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < LANES; g = g + 1) begin : g_lane
         lane_trainer #(
            .WAIT_CYCLES(WAIT_CYCLES)
         ) u_trainer (
            .clk(clk),
            .srst(srst),
            .train_en(train_en), // [RULE16]
            .restart(train_restart), // [RULE17]
            .frame_seen(frame_seen[g]),
            .lane_ready(lane_ready[g]),
            .lane_fail(lane_fail[g]),
            .status(lane_status[g])
         );

         error_counter #(
            .WIDTH(16)
         ) u_errcnt (
            .clk(clk),
            .srst(srst),
            .soft_reset(soft_reset),
            .enable(prbs_drive.chk_en), // [RULE15]
            .bit_err(bit_err[g]),
            .clear(err_clear[g]),
            .count(err_count[g])
         );

         assign err_clear[g] = setup && !req.pwrite && aligned(req.paddr)
                               && is_counter(idx, g); // [RULE15]
         assign irq_event[g] = lane_status[g].fail
                               && !lane_status_q[g].fail;
         assign irq_event[LANES+g] = lane_status[g].ready
                                     && !lane_status_q[g].ready;
      end
   endgenerate

   // ---------------------------------------------------------------
   // apb handshake, no wait states
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   // ---------------------------------------------------------------
   // read data mux
   // ---------------------------------------------------------------
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      if (!aligned(req.paddr)) begin
         next_err = 1'b1;
      end else if (idx == IDX_TRAIN_STATUS) begin
         next_rdata[15:0] = status_word; // [RULE1] [RULE2] [RULE3] [RULE4]
      end else if (idx == IDX_ABILITY) begin
         next_rdata[15:0] = ABILITY_VALUE; // [RULE5] [RULE6] [RULE7]
      end else if (idx == IDX_PRBS_CTL) begin
         next_rdata[15:0] = prbs_ctl; // [RULE13] [RULE19]
      end else if (idx == IDX_TRAIN_CTL) begin
         next_rdata[BIT_TRAIN_EN] = train_en;
         next_rdata[BIT_TRAIN_RESTART] = train_restart;
      end else if (idx >= IDX_ERR_CNT0 &&
                   idx < IDX_ERR_CNT0 + 14'(LANES)) begin
         next_rdata[15:0] = err_count[2'(idx - IDX_ERR_CNT0)];
      end else if (idx == IDX_IRQ_STATUS) begin
         next_rdata[2*LANES-1:0] = irq_status;
      end else if (idx == IDX_IRQ_MASK) begin
         next_rdata[2*LANES-1:0] = irq_mask;
      end else begin
         next_err = 1'b1;
      end
      if (ABILITY_VALUE[BIT_RX_CHK_EN] == 1'b0) begin
         next_err = 1'b1; // [RULE8] [RULE9]
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata <= req.pwrite ? 32'h0000_0000 : next_rdata;
         pslverr <= next_err;
      end else begin
         pslverr <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // pattern test control word
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst || soft_reset) begin
         prbs_ctl <= PRBS_CTL_RESET; // [RULE10] [RULE11]
      end else if (write_done && idx == IDX_PRBS_CTL) begin
         prbs_ctl <= 16'h0000;
         prbs_ctl[BIT_PRBS31_SEL] <= req.pwdata[BIT_PRBS31_SEL]; // [RULE10]
         prbs_ctl[BIT_PRBS9_SEL] <= req.pwdata[BIT_PRBS9_SEL]; // [RULE11]
         prbs_ctl[BIT_TX_GEN_EN] <= req.pwdata[BIT_TX_GEN_EN]; // [RULE12]
         prbs_ctl[BIT_RX_CHK_EN] <= req.pwdata[BIT_RX_CHK_EN]; // [RULE14]
      end
   end

   // ---------------------------------------------------------------
   // drive to the pattern logic
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         prbs_drive <= '0;
      end else begin
         prbs_drive.gen_en <= prbs_ctl[BIT_TX_GEN_EN]; // [RULE12]
         prbs_drive.chk_en <= prbs_ctl[BIT_RX_CHK_EN]; // [RULE14]
         prbs_drive.sel_prbs31 <= prbs_ctl[BIT_PRBS31_SEL]; // [RULE10]
         prbs_drive.sel_prbs9 <= prbs_ctl[BIT_PRBS9_SEL]
                                 && !prbs_ctl[BIT_PRBS31_SEL]; // [RULE19]
      end
   end

   // ---------------------------------------------------------------
   // training control, kept across soft reset
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         train_en <= 1'b0;
      end else if (write_done && idx == IDX_TRAIN_CTL) begin
         train_en <= req.pwdata[BIT_TRAIN_EN]; // [RULE16]
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         train_restart <= 1'b0;
      end else if (write_done && idx == IDX_TRAIN_CTL) begin
         train_restart <= req.pwdata[BIT_TRAIN_RESTART]; // [RULE17]
      end else begin
         train_restart <= 1'b0; // [RULE17]
      end
   end

   // ---------------------------------------------------------------
   // interrupt events: lane failure and lane ready rising edges
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         lane_status_q <= '0;
      end else begin
         lane_status_q <= lane_status;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_status <= '0;
      end else if (write_done && idx == IDX_IRQ_STATUS) begin
         irq_status <= (irq_status & ~req.pwdata[2*LANES-1:0]) | irq_event;
      end else begin
         irq_status <= irq_status | irq_event;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_mask <= '0;
      end else if (write_done && idx == IDX_IRQ_MASK) begin
         irq_mask <= req.pwdata[2*LANES-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end
endmodule : lane_regs

// ### sim/lane_regs_sva.sv
`timescale 1ns/100ps
module lane_regs_sva #(
   parameter int LANES = lane_regs_pkg::NUM_LANES
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic soft_reset,
   input wire logic [lane_regs_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [LANES-1:0] frame_seen,
   input wire logic [LANES-1:0] lane_ready,
   input wire logic [LANES-1:0] lane_fail,
   input wire logic [LANES-1:0] bit_err,
   input wire lane_regs_pkg::prbs_drive_t prbs_drive,
   input wire logic irq
);
   import lane_regs_pkg::*;
   // ------------
   // ctl write tracking
   // ------------
   logic rd_done;
   logic wr_ctl;
   logic [15:0] last_w;
   assign rd_done = psel && penable && pready && !pwrite;
   assign wr_ctl = psel && penable && pready && pwrite && !soft_reset
      && paddr == {IDX_PRBS_CTL, 2'b00};
   always_ff @(posedge clk) begin
      if (wr_ctl) begin
         last_w <= pwdata[15:0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_ability_word: assert property (
      rd_done && paddr == {IDX_ABILITY, 2'b00}
      |-> prdata == 32'h0000_1029) else $error("ability word wrong");
   a_ctl_ro_zero: assert property (
      rd_done && paddr == {IDX_PRBS_CTL, 2'b00}
      |-> (prdata & 32'hffff_ff36) == 0) else $error("ctl ro bits set");
   a_gen_follow: assert property (
      wr_ctl |-> ##[1:2] prbs_drive.gen_en == last_w[3])
      else $error("gen enable wrong");
   a_chk_follow: assert property (
      wr_ctl |-> ##[1:2] prbs_drive.chk_en == last_w[0])
      else $error("checker enable wrong");
   a_sel31_follow: assert property (
      wr_ctl |-> ##[1:2] prbs_drive.sel_prbs31 == last_w[7])
      else $error("prbs31 select wrong");
   a_sel9_prio: assert property (
      wr_ctl |-> ##[1:2] prbs_drive.sel_prbs9 == (last_w[6] & ~last_w[7]))
      else $error("prbs9 select wrong");
   a_ready_setup: assert property (
      psel && !penable |=> pready ##1 !pready)
      else $error("ready timing wrong");
   a_err_unaligned: assert property (
      psel && penable && pready && paddr[1:0] != 0 |-> pslverr)
      else $error("unaligned not refused");
   a_drive_reset: assert property (
      disable iff (1'b0) srst |=> prbs_drive == '0)
      else $error("drive not cleared");
endmodule : lane_regs_sva

bind lane_regs lane_regs_sva #(.LANES(LANES)) u_sva (
   .clk(clk), .srst(srst), .soft_reset(soft_reset), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .frame_seen(frame_seen), .lane_ready(lane_ready),
   .lane_fail(lane_fail), .bit_err(bit_err), .prbs_drive(prbs_drive),
   .irq(irq)
);

// ### sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import lane_regs_pkg::*;
   // ------------
   // stimulus and design
   // ------------
   logic clk = 0, srst = 1, soft_reset = 0, psel = 0, penable = 0;
   logic pwrite = 0, pready, pslverr, irq, er;
   logic [15:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, w, x = 22;
   logic [3:0] frame_seen = 0, lane_ready = 0, lane_fail = 0, bit_err = 0;
   prbs_drive_t prbs_drive;
   int bad_count = 0, checked = 0, n;
   always #2.5 clk = ~clk;
   lane_regs #(.WAIT_CYCLES(32)) dut (
      .clk(clk), .srst(srst), .soft_reset(soft_reset), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frame_seen(frame_seen), .lane_ready(lane_ready),
      .lane_fail(lane_fail), .bit_err(bit_err), .prbs_drive(prbs_drive),
      .irq(irq)
   );
   function automatic logic [31:0] nxt(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : nxt
   function automatic logic [15:0] ba(input logic [13:0] i);
      return {i, 2'b00};
   endfunction : ba
   function automatic logic [31:0] drv_exp(input logic [31:0] d);
      return {28'h000_0000, d[3], d[0], d[7], d[6] & ~d[7]};
   endfunction : drv_exp
   task finish_test;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask : chk
   task xfer(input logic [15:0] a, input logic wt, input logic [31:0] d);
      int k;
      k = 0;
      paddr <= a;
      pwrite <= wt;
      pwdata <= d;
      psel <= 1;
      @(posedge clk);
      penable <= 1;
      @(negedge clk);
      while (pready !== 1'b1) begin
         k++;
         if (k > 20) begin
            bad_count++;
            finish_test;
         end
         @(negedge clk);
      end
      rd = prdata;
      er = pslverr;
      @(posedge clk);
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask : xfer
   task wr(input logic [13:0] i, input logic [31:0] d);
      xfer(ba(i), 1, d);
   endtask : wr
   task rg(input logic [13:0] i);
      xfer(ba(i), 0, 32'h0000_0000);
   endtask : rg
   initial begin
      repeat (16) @(posedge clk);
      srst <= 0;
      @(posedge clk);
      wr(IDX_ABILITY, 32'hffff_ffff);
      rg(IDX_TRAIN_STATUS);
      chk("status", 0, rd);
      rg(IDX_ABILITY);
      chk("ability", 32'h0000_1029, rd);
      rg(IDX_PRBS_CTL);
      chk("ctl", 0, rd);
      rg(14'h0100);
      chk("unmapped err", 1, er);
      chk("unmapped data", 0, rd);
      xfer(ba(IDX_ABILITY) | 16'h0001, 0, 32'h0000_0000);
      chk("unaligned err", 1, er);
      $display("test reset done");
      for (int k = 0; k < 10; k++) begin
         x = nxt(x);
         w = (k == 0) ? 32'h0000_ffff : (k == 1) ? 32'h0000_0000 : x;
         wr(IDX_PRBS_CTL, w);
         rg(IDX_PRBS_CTL);
         chk("ctl", w & 32'h0000_00c9, rd);
         chk("drive", drv_exp(w), prbs_drive);
      end
      $display("test control done");
      wr(IDX_PRBS_CTL, 32'h0000_0001);
      rg(IDX_ERR_CNT0);
      n = 1 + x[2:0];
      repeat (n) begin
         bit_err <= 4'h1;
         @(posedge clk);
         bit_err <= 4'h0;
         @(posedge clk);
      end
      rg(IDX_ERR_CNT0);
      chk("err0", n, rd);
      rg(IDX_ERR_CNT0);
      chk("err0 clear", 0, rd);
      bit_err <= 4'h2;
      repeat (65540) @(posedge clk);
      bit_err <= 4'h0;
      rg(IDX_ERR_CNT0 + 14'h0001);
      chk("err1 sat", 32'h0000_ffff, rd);
      $display("test errors done");
      frame_seen <= 4'h5;
      lane_ready <= 4'h1;
      lane_fail <= 4'h2;
      wr(IDX_TRAIN_CTL, 32'h0000_0002);
      repeat (4) @(posedge clk);
      rg(IDX_TRAIN_STATUS);
      chk("train", 16'h4683, rd & 16'hffbf);
      repeat (40) @(posedge clk);
      rg(IDX_TRAIN_STATUS);
      chk("timeout", 16'h8a83, rd & 16'hbbbf);
      soft_reset <= 1;
      @(posedge clk);
      soft_reset <= 0;
      rg(IDX_TRAIN_STATUS);
      chk("soft keep", 16'h8a83, rd & 16'hbbbf);
      rg(IDX_PRBS_CTL);
      chk("soft ctl", 0, rd);
      chk("soft drive", 0, prbs_drive);
      $display("test training done");
      chk("irq masked", 0, irq);
      rg(IDX_IRQ_STATUS);
      chk("irq status", 4'he, rd[3:0]);
      wr(IDX_IRQ_MASK, 32'h0000_000f);
      @(posedge clk);
      chk("irq on", 1, irq);
      wr(IDX_IRQ_STATUS, 32'h0000_00ff);
      @(posedge clk);
      chk("irq cleared", 0, irq);
      $display("test irq done");
      wr(IDX_TRAIN_CTL, 32'h0000_0003);
      repeat (4) @(posedge clk);
      rg(IDX_TRAIN_STATUS);
      chk("restart", 8'h46, rd[15:8]);
      wr(IDX_TRAIN_CTL, 32'h0000_0000);
      repeat (4) @(posedge clk);
      rg(IDX_TRAIN_STATUS);
      chk("disabled", 16'h0000, rd);
      $display("test restart done");
      finish_test;
   end
endmodule : tb_top
